// ===== rtl/audio_dac_control_regs.sv
`timescale 1ns/10ps
// Contract
// - b15 read flag, 7-bit index, 8 data
// - rolloff bit: sharp cleared, slow set
// - divide bit: full or half clock
// - disable bit stops clock output
// - three-bit field selects audio format
// - two-bit field selects de-emphasis rate
// - rate applies only to enabled pairs
// - three enables for pairs a, b, c
// - invert bit flips all six channels
// - inversion forces all zero flags low; counters keep running
// - increment bit: single or multi read
// - read index resets 01, names register
// - auto read stops at read index
// - user enable drives pins from bits
// - otherwise pins show zero flags
// - oversampling bit picks ratio pair
// - zero after 1024 all-zero samples
// - per-channel flag, combined flag all six
module audio_dac_control_regs
    import dac_ctrl_pkg::*;
#(
    parameter int ZERO_LEN = ZERO_SAMPLES
) (
    input  wire logic              mclk_in,
    input  wire logic              rst_in,
    input  wire logic              word_valid_in,
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic              sample_strobe_in,
    input  wire logic [5:0]        sample_zero_in,
    output logic                   busy_out,
    output logic                   rd_valid_out,
    output logic [WORD_W-1:0]      rd_word_out,
    output dac_cfg_t               cfg_out,
    output logic                   sck_tick_out,
    output logic [5:0]             zero_detect_out,
    output logic [5:0]             user_pins_out,
    output logic                   zero_flag_all_out
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0]  filter_r;
    logic [7:0]  format_r;
    logic [7:0]  readback_r;
    logic [7:0]  user_r;

    typedef enum logic {
        RD_IDLE,
        RD_BURST
    } rd_state_t;

    rd_state_t   rd_state_r;
    logic [6:0]  burst_idx_r;
    logic [6:0]  burst_idx_nxt;
    logic        wr_req;
    logic        rd_req;
    logic [6:0]  req_idx;
    logic [7:0]  req_data;
    logic [6:0]  burst_last;
    dac_cfg_t    cfg_nxt;

    // unimplemented indices read as zero; attenuators live elsewhere
    function automatic logic [7:0] read_reg(input logic [6:0] idx,
                                            input logic [7:0] f9,
                                            input logic [7:0] f10,
                                            input logic [7:0] f11,
                                            input logic [7:0] f12);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_FILTER:   v = f9 & MASK_FILTER;
            IDX_FORMAT:   v = f10 & MASK_FORMAT;
            IDX_READBACK: v = f11 & MASK_READBACK;
            IDX_USER:     v = f12 & MASK_USER;
            default:      v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic [WORD_W-1:0] pack_word(input logic [6:0] idx, input logic [7:0] d);
        return {1'b1, idx, d};
    endfunction

    // write strobe for one register; wr_req is already low during a burst,
    // so a write that arrives while busy never lands
    function automatic logic write_hit(input logic       req,
                                       input logic [6:0] req_i,
                                       input logic [6:0] reg_i);
        return req && (req_i == reg_i);
    endfunction

    // ------------------------------------------------------------
    // word decode
    // ------------------------------------------------------------
    assign req_idx  = word_in[IDX_HI:IDX_LO];
    assign req_data = word_in[DATA_W-1:0];
    assign wr_req   = word_valid_in && (rd_state_r == RD_IDLE) && (word_in[RW_POS] == RW_WRITE);
    assign rd_req   = word_valid_in && (rd_state_r == RD_IDLE) && (word_in[RW_POS] != RW_WRITE);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // each register keeps only its implemented bits, so reserved bits read 0
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            filter_r <= RST_FILTER;
        end else if (write_hit(wr_req, req_idx, IDX_FILTER)) begin
            filter_r <= req_data & MASK_FILTER;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            format_r <= RST_FORMAT;
        end else if (write_hit(wr_req, req_idx, IDX_FORMAT)) begin
            format_r <= req_data & MASK_FORMAT;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            readback_r <= RST_READBACK;
        end else if (write_hit(wr_req, req_idx, IDX_READBACK)) begin
            readback_r <= req_data & MASK_READBACK;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            user_r <= RST_USER;
        end else if (write_hit(wr_req, req_idx, IDX_USER)) begin
            user_r <= req_data & MASK_USER;
        end
    end

    // ------------------------------------------------------------
    // readback sequencer
    // ------------------------------------------------------------
    // the read index doubles as the final index of a burst
    assign burst_last = readback_r[6:0];

    // a burst emits one word per cycle; further words are refused while busy
    always_comb begin
        burst_idx_nxt = burst_idx_r + 7'h01;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_state_r   <= RD_IDLE;
            burst_idx_r  <= IDX_FIRST;
            rd_valid_out <= 1'b0;
            rd_word_out  <= 16'h0000;
            busy_out     <= 1'b0;
        end else begin
            rd_valid_out <= 1'b0;
            case (rd_state_r)
                RD_IDLE: begin
                    if (rd_req) begin
                        rd_valid_out <= 1'b1;
                        if (readback_r[INC_POS]) begin
                            rd_word_out <= pack_word(IDX_FIRST,
                                read_reg(IDX_FIRST, filter_r, format_r, readback_r, user_r));
                            if (burst_last > IDX_FIRST) begin
                                rd_state_r  <= RD_BURST;
                                burst_idx_r <= IDX_FIRST + 7'h01;
                                busy_out    <= 1'b1;
                            end
                        end else begin
                            // a single read ignores the index field of the word itself
                            rd_word_out <= pack_word(readback_r[6:0],
                                read_reg(readback_r[6:0], filter_r, format_r, readback_r, user_r));
                        end
                    end
                end
                RD_BURST: begin
                    rd_valid_out <= 1'b1;
                    rd_word_out  <= pack_word(burst_idx_r,
                        read_reg(burst_idx_r, filter_r, format_r, readback_r, user_r));
                    if (burst_idx_r >= burst_last) begin
                        rd_state_r  <= RD_IDLE;
                        busy_out    <= 1'b0;
                        burst_idx_r <= IDX_FIRST;
                    end else begin
                        burst_idx_r <= burst_idx_nxt;
                    end
                end
                default: begin
                    rd_state_r <= RD_IDLE;
                    busy_out   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration outputs
    // ------------------------------------------------------------
    // reserved codes pass through unchanged; the host must not write them
    always_comb begin
        cfg_nxt                     = '0;
        cfg_nxt.rolloff_select      = filter_r[ROLLOFF_POS];
        cfg_nxt.audio_format_select = audio_format_t'(filter_r[FMT_LO +: 3]);
        cfg_nxt.deemph_rate_select  = deemph_rate_t'(format_r[DMF_LO +: 2]);
        cfg_nxt.deemph_active       = format_r[DMEN_LO +: 3];
        cfg_nxt.phase_invert        = format_r[INVERT_POS];
        cfg_nxt.os_ratio_low        = user_r[OVER_POS] ? OS_128 : OS_64;
        cfg_nxt.os_ratio_high       = user_r[OVER_POS] ? OS_64 : OS_32;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cfg_out <= '0;
        end else begin
            cfg_out <= cfg_nxt;
        end
    end

    // ------------------------------------------------------------
    // system clock output enable
    // ------------------------------------------------------------
    // the output is an enable pulse, not a clock: full rate pulses every cycle
    // the divider runs freely, so a divide change settles within two cycles
    logic half_phase_r;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            half_phase_r <= 1'b0;
        end else begin
            half_phase_r <= ~half_phase_r;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sck_tick_out <= 1'b0;
        end else if (filter_r[CLKDIS_POS]) begin
            sck_tick_out <= 1'b0;
        end else if (filter_r[CLKDIV_POS]) begin
            sck_tick_out <= half_phase_r;
        end else begin
            sck_tick_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // zero detection
    // ------------------------------------------------------------
    localparam logic [ZCNT_W-1:0] ZERO_FULL = ZCNT_W'(ZERO_LEN);

    logic [ZCNT_W-1:0] zero_cnt_r [CHANNELS];
    logic [5:0]        zero_hit;
    logic [5:0]        zero_flags;

    // counters saturate so a long silence keeps the flag without wrapping
    always_ff @(posedge mclk_in) begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            if (rst_in) begin
                zero_cnt_r[ch] <= '0;
            end else if (sample_strobe_in) begin
                if (!sample_zero_in[ch]) begin
                    zero_cnt_r[ch] <= '0;
                end else if (zero_cnt_r[ch] != ZERO_FULL) begin
                    zero_cnt_r[ch] <= zero_cnt_r[ch] + ZCNT_W'(1);
                end
            end
        end
    end

    always_comb begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
            zero_hit[ch] = (zero_cnt_r[ch] == ZERO_FULL);
        end
        // counters keep running under inversion, so flags return at once when it ends
        zero_flags = format_r[INVERT_POS] ? 6'h00 : zero_hit;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            zero_detect_out   <= 6'h00;
            zero_flag_all_out <= 1'b0;
        end else begin
            zero_detect_out   <= zero_flags;
            zero_flag_all_out <= &zero_flags;
        end
    end

    // the shared pins fall back to the zero flags whenever user output is off
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            user_pins_out <= 6'h00;
        end else if (user_r[UOE_POS]) begin
            user_pins_out <= user_r[UBIT_LO +: 6];
        end else begin
            user_pins_out <= zero_flags;
        end
    end

endmodule

// ===== rtl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------
    localparam int          WORD_W        = 16;
    localparam int          RW_POS        = 15;
    localparam int          IDX_HI        = 14;
    localparam int          IDX_LO        = 8;
    localparam int          IDX_W         = 7;
    localparam int          DATA_W        = 8;
    localparam logic        RW_WRITE      = 1'b0;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [6:0]  IDX_FIRST     = 7'h01;
    localparam logic [6:0]  IDX_FILTER    = 7'h09;
    localparam logic [6:0]  IDX_FORMAT    = 7'h0a;
    localparam logic [6:0]  IDX_READBACK  = 7'h0b;
    localparam logic [6:0]  IDX_USER      = 7'h0c;

    // ------------------------------------------------------------
    // implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  MASK_FILTER   = 8'h3f;
    localparam logic [7:0]  MASK_FORMAT   = 8'h3f;
    localparam logic [7:0]  MASK_READBACK = 8'hff;
    localparam logic [7:0]  MASK_USER     = 8'hff;
    localparam logic [7:0]  RST_FILTER    = 8'h00;
    localparam logic [7:0]  RST_FORMAT    = 8'h00;
    localparam logic [7:0]  RST_READBACK  = 8'h01;
    localparam logic [7:0]  RST_USER      = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int          ROLLOFF_POS   = 5;
    localparam int          CLKDIV_POS    = 4;
    localparam int          CLKDIS_POS    = 3;
    localparam int          FMT_LO        = 0;
    localparam int          INVERT_POS    = 5;
    localparam int          DMF_LO        = 3;
    localparam int          DMEN_LO       = 0;
    localparam int          INC_POS       = 7;
    localparam int          OVER_POS      = 7;
    localparam int          UOE_POS       = 6;
    localparam int          UBIT_LO       = 0;

    // ------------------------------------------------------------
    // ratios and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  OS_64         = 8'h40;
    localparam logic [7:0]  OS_32         = 8'h20;
    localparam logic [7:0]  OS_128        = 8'h80;
    localparam int          ZERO_SAMPLES  = 1024;
    localparam int          ZCNT_W        = 11;
    localparam int          CHANNELS      = 6;

    typedef enum logic [2:0] {
        FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16, FMT_I2S, FMT_LJ, FMT_RSV6, FMT_RSV7
    } audio_format_t;

    typedef enum logic [1:0] {
        DEEMPH_44K1, DEEMPH_48K, DEEMPH_32K, DEEMPH_RSV
    } deemph_rate_t;

    typedef struct packed {
        logic          rolloff_select;
        audio_format_t audio_format_select;
        deemph_rate_t  deemph_rate_select;
        logic [2:0]    deemph_active;
        logic          phase_invert;
        logic [7:0]    os_ratio_low;
        logic [7:0]    os_ratio_high;
    } dac_cfg_t;

endpackage

// ===== bench/host_ctrl_model.sv
`timescale 1ns/10ps
module host_ctrl_model
    import dac_ctrl_pkg::*;
(
    input  wire logic         mclk_in,
    output logic              word_valid_out,
    output logic [WORD_W-1:0] word_out
);
    initial begin
        word_valid_out = 1'b0;
        word_out = 16'h0000;
    end

    // one word per call; a call spans two edges so valid never toggles twice at one edge
    task automatic send(input logic [WORD_W-1:0] w);
        @(posedge mclk_in);
        word_valid_out <= 1'b1;
        word_out <= w;
        @(posedge mclk_in);
        word_valid_out <= 1'b0;
        word_out <= ~w;
    endtask
endmodule

// ===== bench/audio_dac_control_regs_chk.sv
`timescale 1ns/10ps
module audio_dac_control_regs_chk
    import dac_ctrl_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic        word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic        busy_out,
    input wire logic        rd_valid_out,
    input wire logic [15:0] rd_word_out,
    input wire dac_cfg_t    cfg_out,
    input wire logic [5:0]  zero_detect_out,
    input wire logic        zero_flag_all_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence s_rd_taken;
        word_valid_in && !busy_out && word_in[RW_POS];
    endsequence
    sequence s_wr_taken;
        word_valid_in && !busy_out && !word_in[RW_POS];
    endsequence

    a_read_answer: assert property (s_rd_taken |=> rd_valid_out && rd_word_out[15])
        else $error("read word not answered next cycle");
    a_write_quiet: assert property (s_wr_taken |=> !rd_valid_out)
        else $error("write produced read data");
    a_invert_mute: assert property (cfg_out.phase_invert |-> zero_detect_out == 6'h00)
        else $error("zero detect active while inverted");
    a_all_flag: assert property (zero_flag_all_out |-> (&zero_detect_out) || (&$past(zero_detect_out)))
        else $error("combined flag without all six flags");
    a_os_pair: assert property (!$past(rst_in) |->
        (cfg_out.os_ratio_low == OS_64 && cfg_out.os_ratio_high == OS_32)
        || (cfg_out.os_ratio_low == OS_128 && cfg_out.os_ratio_high == OS_64))
        else $error("oversampling ratio pair invalid");
    a_burst_steady: assert property (busy_out |-> rd_valid_out)
        else $error("burst cycle without read word");
    a_burst_ascend: assert property (busy_out |=> rd_valid_out
        && rd_word_out[IDX_HI:IDX_LO] == $past(rd_word_out[IDX_HI:IDX_LO]) + 7'd1)
        else $error("burst index not ascending");
    a_burst_start: assert property ($rose(busy_out) |-> rd_word_out[IDX_HI:IDX_LO] == IDX_FIRST)
        else $error("burst does not start at first index");
    a_burst_end: assert property ($fell(busy_out) && !word_valid_in |-> rd_valid_out ##1 !rd_valid_out)
        else $error("burst does not stop after final index");
endmodule

bind audio_dac_control_regs audio_dac_control_regs_chk chk_u (.mclk_in(mclk_in), .rst_in(rst_in),
    .word_valid_in(word_valid_in), .word_in(word_in), .busy_out(busy_out), .rd_valid_out(rd_valid_out),
    .rd_word_out(rd_word_out), .cfg_out(cfg_out), .zero_detect_out(zero_detect_out),
    .zero_flag_all_out(zero_flag_all_out));

// ===== bench/audio_dac_control_regs_tb_top.sv
`timescale 1ns/10ps
module audio_dac_control_regs_tb_top
    import dac_ctrl_pkg::*;
;
    localparam int ZLEN = 4;
    typedef struct packed {logic [6:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
    logic        mclk_in, rst_in, word_valid_in, sample_strobe_in;
    logic        busy_out, rd_valid_out, sck_tick_out, zero_flag_all_out;
    logic [15:0] word_in, rd_word_out, w;
    logic [5:0]  sample_zero_in, zero_detect_out, user_pins_out;
    logic [7:0]  d;
    logic [1:0]  s;
    dac_cfg_t    cfg_out;
    int          mismatches, total_checks, cycles;
    logic [15:0] seen_q[$];
    // last row leaves an unmapped index, which must read as zero
    row_t rows[8] = '{'{7'h09, 8'he5, 8'h25}, '{7'h09, 8'h1c, 8'h1c}, '{7'h09, 8'h10, 8'h10},
        '{7'h0a, 8'hf7, 8'h37}, '{7'h0a, 8'h09, 8'h09}, '{7'h0c, 8'hc5, 8'hc5},
        '{7'h0c, 8'h3a, 8'h3a}, '{7'h0d, 8'hff, 8'h00}};

    host_ctrl_model host_u (.mclk_in(mclk_in), .word_valid_out(word_valid_in), .word_out(word_in));
    audio_dac_control_regs #(.ZERO_LEN(ZLEN)) dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
        .word_valid_in(word_valid_in), .word_in(word_in), .sample_strobe_in(sample_strobe_in),
        .sample_zero_in(sample_zero_in), .busy_out(busy_out), .rd_valid_out(rd_valid_out),
        .rd_word_out(rd_word_out), .cfg_out(cfg_out), .sck_tick_out(sck_tick_out),
        .zero_detect_out(zero_detect_out), .user_pins_out(user_pins_out),
        .zero_flag_all_out(zero_flag_all_out));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        if (rd_valid_out === 1'b1) seen_q.push_back(rd_word_out);
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [6:0] i, input logic [7:0] v);
        host_u.send({RW_WRITE, i, v});
    endtask

    // single read through the readback index; returns the whole answer word
    task automatic rd(input logic [6:0] i, output logic [15:0] r);
        wr(IDX_READBACK, {1'b0, i});
        seen_q.delete();
        host_u.send(16'h8000);
        repeat (2) @(posedge mclk_in);
        #1 r = (seen_q.size() == 1) ? seen_q[0] : 16'hxxxx;
    endtask

    task automatic zs(input logic [5:0] z);
        @(posedge mclk_in);
        sample_strobe_in <= 1'b1;
        sample_zero_in <= z;
        @(posedge mclk_in);
        sample_strobe_in <= 1'b0;
        sample_zero_in <= ~z;
    endtask

    initial begin
        rst_in = 1'b1;
        sample_strobe_in = 1'b0;
        sample_zero_in = 6'h00;
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        seen_q.delete();
        host_u.send(16'h8000);
        repeat (2) @(posedge mclk_in);
        #1 chk(32'(seen_q.size()), 32'd1);
        chk(32'(seen_q[0]), 32'h0000_8100);
        chk(32'(cfg_out), 32'({1'b0, 3'd0, 2'd0, 3'd0, 1'b0, OS_64, OS_32}));
        foreach (rows[k]) begin
            wr(rows[k].idx, rows[k].wd);
            @(posedge mclk_in);
            #1 d = rows[k].wd;
            if (rows[k].idx == IDX_FILTER) begin
                chk({cfg_out.rolloff_select, cfg_out.audio_format_select}, {d[5], d[2:0]});
                s = 2'd0;
                repeat (2) begin
                    @(posedge mclk_in);
                    #1 s = s + sck_tick_out;
                end
                chk(s, d[3] ? 0 : d[4] ? 1 : 2);
            end
            if (rows[k].idx == IDX_FORMAT) begin
                chk({cfg_out.phase_invert, cfg_out.deemph_rate_select, cfg_out.deemph_active}, d[5:0]);
            end
            if (rows[k].idx == IDX_USER) begin
                chk({cfg_out.os_ratio_low, cfg_out.os_ratio_high}, d[7] ? {OS_128, OS_64} : {OS_64, OS_32});
                chk(user_pins_out, d[6] ? d[5:0] : 6'h00);
            end
            rd(rows[k].idx, w);
            chk(w, {1'b1, rows[k].idx, rows[k].rd});
        end
        for (int f = 3; f >= 0; f--) begin
            wr(IDX_FILTER, 8'(f));
            @(posedge mclk_in);
            #1 chk(cfg_out.audio_format_select, f);
        end
        wr(IDX_READBACK, 8'h8c);
        seen_q.delete();
        host_u.send(16'h8000);
        host_u.send({RW_WRITE, IDX_FILTER, 8'h3f});
        repeat (14) @(posedge mclk_in);
        #1 chk(32'(seen_q.size()), 32'd12);
        for (int k = 1; k <= 12; k++) begin
            d = (k == 10) ? 8'h09 : (k == 11) ? 8'h8c : (k == 12) ? 8'h3a : 8'h00;
            chk(seen_q[k-1], {1'b1, 7'(k), d});
        end
        rd(IDX_FILTER, w);
        chk(w, 16'h8900);
        repeat (ZLEN - 1) zs(6'h3f);
        repeat (3) @(posedge mclk_in);
        #1 chk({zero_detect_out, zero_flag_all_out}, 7'h00);
        zs(6'h3f);
        repeat (2) @(posedge mclk_in);
        #1 chk({zero_detect_out, zero_flag_all_out, user_pins_out}, {6'h3f, 1'b1, 6'h3f});
        zs(6'h3b);
        repeat (3) @(posedge mclk_in);
        #1 chk({zero_detect_out, zero_flag_all_out}, {6'h3b, 1'b0});
        wr(IDX_FORMAT, 8'h20);
        @(posedge mclk_in);
        #1 chk({cfg_out.phase_invert, zero_detect_out}, 7'h40);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(IDX_FORMAT, w);
        chk(w, 16'h8a00);
        chk(32'(cfg_out), 32'({1'b0, 3'd0, 2'd0, 3'd0, 1'b0, OS_64, OS_32}));
        chk({zero_detect_out, zero_flag_all_out, user_pins_out, busy_out}, 14'h0000);
        chk(sck_tick_out, 1'b1);
        finish_test();
    end
endmodule
